// File: hw/vad_dialer.sv
// voice alarm dialer sequencer with ahb-lite registers
// Behaviour
// - correct password on check call: message 2, then message 4 if no alarm
// - repeat message 4 while off-hook, hang up after repeat count, go idle
// - repeat count programmable, default 5, only 2 to 5 accepted
// - wrong password plays message 3 then message 1
// - door alarm starts primary dial block calling its preset number
// - answered call: prompt for #0, then message 1 or selected message
// - correct password on alarm call: message 2, repeat selected message, hang up
// - unanswered call rings configured times, keeps the line held, redials configured times
// - primary exhausted: dial secondary block; if that fails, assert failure output
// - star during the password prompt stops playback; four digits within 9 s, else prompt again
// - fourth wrong password hangs up and returns to idle
// - alarm still active: redial every 40 seconds
`timescale 1ns/1ps
`include "vad_cfg.svh"
module vad_dialer
	import vad_pkg::*;
#(
	parameter logic [31:0] PWD_WAIT_CYC = 32'(`VAD_PWD_WAIT_CYC),
	parameter logic [31:0] RETRY_CYC    = 32'(`VAD_RETRY_CYC)
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        door_alarm_input,
	input  wire logic        incoming_ring,
	input  wire logic        line_offhook,
	input  wire logic        ringback,
	input  wire logic        key_valid,
	input  wire logic [3:0]  key_code,
	input  wire logic        play_done,
	output logic             line_hook,
	output logic             dial_req,
	output logic             dial_block,
	output logic             play_start,
	output logic [3:0]       play_msg,
	output logic             play_stop,
	output logic             dial_failure_output
);
	vad_state_s q;
	vad_state_s d;
	logic [5:0] rise;
	logic       key_ev;
	logic [3:0] key;
	logic       done_ev;
	logic       offhook;
	logic       alarm;
	logic       acc;
	logic       pwd_full;
	logic [15:0] pwd_val;

	assign rise     = q.s2[9:4] & ~q.prv;
	assign alarm    = q.s2[9];
	assign offhook  = q.s2[7];
	assign key_ev   = rise[1];
	assign done_ev  = rise[0];
	assign key      = q.s2[3:0];
	assign acc      = hsel & htrans[1] & hready;
	assign pwd_val  = {q.digits[11:0], key};
	assign pwd_full = (q.st == VAD_PWD_ENTRY) && key_ev && (key != `VAD_KEY_STAR)
		&& (key != `VAD_KEY_HASH) && (q.dcnt == 3'h3);

	always_comb
	begin
		d            = q;
		d.s1         = {door_alarm_input, incoming_ring, line_offhook, ringback,
			key_valid, play_done, key_code};
		d.s2         = q.s1;
		d.prv        = q.s2[9:4];
		d.dial_req   = 1'b0;
		d.play_start = 1'b0;
		d.play_stop  = 1'b0;
		// register writes in the data phase
		if (q.wr_pend)
		begin
			case (q.wr_ofs)
				`VAD_OFS_CTRL:
				begin
					if (hwdata[2:0] >= `VAD_REP_MIN && hwdata[2:0] <= `VAD_REP_MAX)
						d.rep_n = hwdata[2:0];
					d.pwd_en  = hwdata[3];
					d.sel_msg = hwdata[7:4];
				end
				`VAD_OFS_DIAL:
				begin
					d.rings   = hwdata[3:0];
					d.redials = hwdata[7:4];
				end
				`VAD_OFS_PWD:    d.pwd = hwdata[15:0];
				`VAD_OFS_STATUS: if (hwdata[1]) d.fail = 1'b0;
				default:         d.pwd = q.pwd;
			endcase
		end
		d.wr_pend = acc & hwrite & (haddr[31:4] == 28'h0);
		d.wr_ofs  = {haddr[3:2], 2'b00};
		d.hrdata  = 32'h0;
		if (acc && !hwrite && haddr[31:4] == 28'h0)
		begin
			case ({haddr[3:2], 2'b00})
				`VAD_OFS_CTRL:   d.hrdata = {24'h0, q.sel_msg, q.pwd_en, q.rep_n};
				`VAD_OFS_DIAL:   d.hrdata = {24'h0, q.redials, q.rings};
				`VAD_OFS_PWD:    d.hrdata = {16'h0, q.pwd};
				default:         d.hrdata = {20'h0, 4'(q.st), 1'b0, q.dial_blk,
					q.wrong, 1'b0, alarm, q.fail, q.hook};
			endcase
		end
		if (q.timer != 32'h0)
			d.timer = q.timer - 32'h1;
		// caller gone: drop the call
		if (q.hook && !offhook && q.st != VAD_DIALING && q.st != VAD_HANGUP)
			d.st = VAD_HANGUP;
		else
		begin
			case (q.st)
				VAD_IDLE:
				begin
					if (q.retry != 32'h0)
						d.retry = q.retry - 32'h1;
					if (q.alarm_pend)
					begin
						d.alarm_pend = 1'b0;
						d.hook       = 1'b1;
						d.dial_req   = 1'b1;
						d.dial_blk   = 1'b0;
						d.st         = VAD_DIALING;
					end
					else if (rise[4])
					begin
						d.hook       = 1'b1;
						d.incoming   = 1'b1;
						d.play_start = 1'b1;
						d.play_msg   = `VAD_MSG_PWD;
						d.st         = VAD_PROMPT;
					end
				end
				VAD_PROMPT:
				begin
					if (key_ev && key == `VAD_KEY_STAR)
					begin
						d.play_stop = 1'b1;
						d.dcnt      = 3'h0;
						d.timer     = PWD_WAIT_CYC;
						d.st        = VAD_PWD_ENTRY;
					end
					else if (done_ev)
						d.play_start = 1'b1;
				end
				VAD_PWD_ENTRY:
				begin
					if (q.timer == 32'h1)
					begin
						d.play_start = 1'b1;
						d.play_msg   = `VAD_MSG_PWD;
						d.st         = VAD_PROMPT;
					end
					else if (key_ev && key != `VAD_KEY_STAR && key != `VAD_KEY_HASH)
					begin
						d.digits = pwd_val;
						d.dcnt   = q.dcnt + 3'h1;
						if (pwd_full && pwd_val == q.pwd)
						begin
							d.play_start = 1'b1;
							d.play_msg   = `VAD_MSG_OK;
							d.st         = VAD_PLAY_OK;
						end
						else if (pwd_full && q.wrong == `VAD_LAST_WRONG)
							d.st = VAD_HANGUP;
						else if (pwd_full)
						begin
							d.wrong      = q.wrong + 2'h1;
							d.play_start = 1'b1;
							d.play_msg   = `VAD_MSG_WRONG;
							d.st         = VAD_PLAY_WRONG;
						end
					end
				end
				VAD_PLAY_WRONG:
				begin
					if (done_ev)
					begin
						d.play_start = 1'b1;
						d.play_msg   = `VAD_MSG_PWD;
						d.st         = VAD_PROMPT;
					end
				end
				VAD_PLAY_OK:
				begin
					if (done_ev)
					begin
						d.play_start = 1'b1;
						d.play_msg   = (q.incoming && !alarm) ? `VAD_MSG_NORMAL : q.sel_msg;
						d.rep        = 3'h1;
						d.st         = VAD_PLAY_REP;
					end
				end
				VAD_PLAY_REP:
				begin
					if (done_ev && q.rep >= q.rep_n)
						d.st = VAD_HANGUP;
					else if (done_ev)
					begin
						d.play_start = 1'b1;
						d.rep        = q.rep + 3'h1;
					end
				end
				VAD_DIALING:
				begin
					if (offhook)
					begin
						d.play_start = 1'b1;
						d.play_msg   = `VAD_MSG_KEY0;
						d.got_hash   = 1'b0;
						d.st         = VAD_WAIT_KEY0;
					end
					else if (rise[2] && q.ring_cnt + 4'h1 < q.rings)
						d.ring_cnt = q.ring_cnt + 4'h1;
					else if (rise[2])
					begin
						d.ring_cnt = 4'h0;
						d.dial_req = 1'b1;
						if (q.redial_cnt < q.redials)
							d.redial_cnt = q.redial_cnt + 4'h1;
						else if (!q.dial_blk)
						begin
							d.dial_blk   = 1'b1;
							d.redial_cnt = 4'h0;
						end
						else
						begin
							d.dial_req = 1'b0;
							d.fail     = 1'b1;
							d.st       = VAD_HANGUP;
						end
					end
				end
				VAD_WAIT_KEY0:
				begin
					if (key_ev)
						d.got_hash = (key == `VAD_KEY_HASH);
					if (key_ev && q.got_hash && key == `VAD_KEY_ZERO)
					begin
						d.play_start = 1'b1;
						d.play_msg   = q.pwd_en ? `VAD_MSG_PWD : q.sel_msg;
						d.rep        = 3'h1;
						d.st         = q.pwd_en ? VAD_PROMPT : VAD_PLAY_REP;
					end
					else if (done_ev)
						d.play_start = 1'b1;
				end
				default:
				begin
					d.hook       = 1'b0;
					d.play_stop  = q.hook;
					d.incoming   = 1'b0;
					d.got_hash   = 1'b0;
					d.wrong      = 2'h0;
					d.rep        = 3'h0;
					d.dcnt       = 3'h0;
					d.ring_cnt   = 4'h0;
					d.redial_cnt = 4'h0;
					d.timer      = 32'h0;
					if (!q.incoming && alarm)
						d.retry = RETRY_CYC;
					d.st = VAD_IDLE;
				end
			endcase
		end
		if (rise[5] || (q.st == VAD_IDLE && q.retry == 32'h1 && alarm))
			d.alarm_pend = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			q         <= '0;
			q.st      <= VAD_IDLE;
			q.rep_n   <= `VAD_RST_REP_N;
			q.rings   <= `VAD_RST_RINGS;
			q.redials <= `VAD_RST_REDIALS;
			q.sel_msg <= `VAD_RST_SEL_MSG;
			q.pwd     <= `VAD_RST_PWD;
		end
		else
			q <= d;
	end

	assign hreadyout           = 1'b1;
	assign hresp               = 1'b0;
	assign hrdata              = q.hrdata;
	assign line_hook           = q.hook;
	assign dial_req            = q.dial_req;
	assign dial_block          = q.dial_blk;
	assign play_start          = q.play_start;
	assign play_msg            = q.play_msg;
	assign play_stop           = q.play_stop;
	assign dial_failure_output = q.fail;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_star_in_prompt;
		q.st == VAD_PROMPT && offhook && key_ev && key == `VAD_KEY_STAR;
	endsequence
	sequence s_hash_zero;
		q.st == VAD_WAIT_KEY0 && offhook && key_ev && q.got_hash && key == `VAD_KEY_ZERO;
	endsequence

	a_repeat_range: assert property (q.rep_n >= 3'h2 && q.rep_n <= 3'h5)
		else $error("repeat count out of range");
	a_repeat_stop: assert property (q.st == VAD_PLAY_REP && offhook && done_ev
		&& q.rep >= q.rep_n |=> q.st == VAD_HANGUP ##1 q.st == VAD_IDLE && !q.hook)
		else $error("no hang-up after repeats");
	a_wrong_msg: assert property (q.st == VAD_PLAY_WRONG && offhook && done_ev
		|=> play_start && play_msg == 4'h1 && q.st == VAD_PROMPT)
		else $error("wrong password not followed by prompt");
	a_alarm_dial: assert property (q.st == VAD_IDLE && q.alarm_pend
		|=> dial_req && !dial_block && line_hook)
		else $error("alarm did not dial primary");
	a_key0_play: assert property (s_hash_zero |=> play_start
		&& play_msg == (q.pwd_en ? 4'h1 : q.sel_msg))
		else $error("wrong message after key 0");
	a_star_stop: assert property (s_star_in_prompt |=> play_stop
		&& q.st == VAD_PWD_ENTRY)
		else $error("star did not stop playback");
	a_fourth_wrong: assert property (offhook && pwd_full && pwd_val != q.pwd
		&& q.wrong == 2'h3 && q.timer != 32'h1 |=> q.st == VAD_HANGUP ##1 !line_hook)
		else $error("fourth wrong entry kept call");
	a_fail_second: assert property ($rose(q.fail) |-> $past(q.dial_blk))
		else $error("failure before secondary block");
	a_hangup_clear: assert property (q.st == VAD_HANGUP |=> q.wrong == 2'h0
		&& q.rep == 3'h0 && !q.incoming)
		else $error("call state not cleared");
endmodule : vad_dialer

// File: include/vad_cfg.svh
// constants of the voice alarm dialer
`ifndef VAD_CFG_SVH
`define VAD_CFG_SVH
`define VAD_CLK_HZ        40000000
`define VAD_PWD_WAIT_S    9
`define VAD_RETRY_S       40
`define VAD_PWD_WAIT_CYC  (`VAD_PWD_WAIT_S * `VAD_CLK_HZ)
`define VAD_RETRY_CYC     (`VAD_RETRY_S * `VAD_CLK_HZ)
`define VAD_OFS_CTRL      4'h0
`define VAD_OFS_DIAL      4'h4
`define VAD_OFS_PWD       4'h8
`define VAD_OFS_STATUS    4'hc
`define VAD_RST_REP_N     3'h5
`define VAD_REP_MIN       3'h2
`define VAD_REP_MAX       3'h5
`define VAD_RST_RINGS     4'h5
`define VAD_RST_REDIALS   4'h2
`define VAD_RST_SEL_MSG   4'h5
`define VAD_RST_PWD       16'h1234
`define VAD_MSG_KEY0      4'h0
`define VAD_MSG_PWD       4'h1
`define VAD_MSG_OK        4'h2
`define VAD_MSG_WRONG     4'h3
`define VAD_MSG_NORMAL    4'h4
`define VAD_KEY_STAR      4'ha
`define VAD_KEY_HASH      4'hb
`define VAD_KEY_ZERO      4'h0
`define VAD_LAST_WRONG    2'h3
`endif

// File: include/vad_pkg.sv
// types of the voice alarm dialer
package vad_pkg;
	typedef enum logic [3:0] {
		VAD_IDLE, VAD_PROMPT, VAD_PWD_ENTRY, VAD_PLAY_OK, VAD_PLAY_WRONG,
		VAD_PLAY_REP, VAD_DIALING, VAD_WAIT_KEY0, VAD_HANGUP
	} vad_state_e;
	typedef struct packed {
		vad_state_e  st;
		logic [9:0]  s1;
		logic [9:0]  s2;
		logic [5:0]  prv;
		logic        hook;
		logic        dial_req;
		logic        dial_blk;
		logic        play_start;
		logic [3:0]  play_msg;
		logic        play_stop;
		logic        fail;
		logic [31:0] hrdata;
		logic        wr_pend;
		logic [3:0]  wr_ofs;
		logic [2:0]  rep_n;
		logic        pwd_en;
		logic [3:0]  sel_msg;
		logic [3:0]  rings;
		logic [3:0]  redials;
		logic [15:0] pwd;
		logic        incoming;
		logic        got_hash;
		logic [15:0] digits;
		logic [2:0]  dcnt;
		logic [1:0]  wrong;
		logic [2:0]  rep;
		logic [3:0]  ring_cnt;
		logic [3:0]  redial_cnt;
		logic [31:0] timer;
		logic [31:0] retry;
		logic        alarm_pend;
	} vad_state_s;
endpackage : vad_pkg

// File: verif/test_vad_dialer.sv
// self-checking bench of the voice alarm dialer
`timescale 1ns/1ps
`include "vad_cfg.svh"
module test_vad_dialer;
	logic        hclk, hresetn, hsel, hwrite, door_alarm_input;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, rd;
	logic [3:0]  key_code, play_msg;
	logic        hreadyout, hresp, incoming_ring, line_offhook, ringback, key_valid;
	logic        play_done, line_hook, dial_req, dial_block, play_start, play_stop;
	logic        dial_failure_output;
	logic [31:0] hrdata;
	logic [3:0]  msgs[$];
	int          err_count, check_count, cyc, stops;
	int          dials[2];
	vad_dialer #(.PWD_WAIT_CYC(32'd400), .RETRY_CYC(32'd300)) u_vad_dialer (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.door_alarm_input(door_alarm_input), .incoming_ring(incoming_ring),
		.line_offhook(line_offhook), .ringback(ringback), .key_valid(key_valid),
		.key_code(key_code), .play_done(play_done), .line_hook(line_hook),
		.dial_req(dial_req), .dial_block(dial_block), .play_start(play_start),
		.play_msg(play_msg), .play_stop(play_stop),
		.dial_failure_output(dial_failure_output));
	vad_phone_line u_vad_phone_line (
		.hclk(hclk), .line_hook(line_hook), .dial_req(dial_req), .play_start(play_start),
		.play_stop(play_stop), .incoming_ring(incoming_ring), .line_offhook(line_offhook),
		.ringback(ringback), .key_valid(key_valid), .key_code(key_code),
		.play_done(play_done));
	initial
	begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (play_start === 1'b1) msgs.push_back(play_msg);
		if (dial_req === 1'b1) dials[dial_block] += 1;
		if (play_stop === 1'b1) stops += 1;
		if (cyc == 40000)
		begin
			err_count += 1;
			complete_run();
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count += 1;
		if (got !== exp)
		begin
			err_count += 1;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic expect_msg(input logic [3:0] m);
		int n;
		n = 0;
		while (msgs.size() == 0 && n < 3000)
		begin
			@(posedge hclk);
			n++;
		end
		chk("play_msg", {28'h0, m}, (msgs.size() > 0) ? {28'h0, msgs.pop_front()} : 'x);
	endtask : expect_msg
	task automatic keys(input logic [15:0] d);
		u_vad_phone_line.press(`VAD_KEY_STAR);
		for (int i = 3; i >= 0; i--) u_vad_phone_line.press(d[i*4 +: 4]);
	endtask : keys
	task automatic wait_hangup();
		int n;
		n = 0;
		while (line_hook !== 1'b0 && n < 3000)
		begin
			@(posedge hclk);
			n++;
		end
		repeat (4) @(posedge hclk);
		chk("line_hook", 32'h0, {31'h0, line_hook});
	endtask : wait_hangup
	task automatic test_regs();
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctrl reset", 32'h55, rd);
		ahb(1'b1, 32'h0, 32'h51);
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctrl rep 1", 32'h55, rd);
		ahb(1'b1, 32'h0, 32'h53);
		ahb(1'b0, 32'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctrl rep 3", 32'h53, rd);
	endtask : test_regs
	task automatic test_check_call();
		u_vad_phone_line.ring_in();
		expect_msg(`VAD_MSG_PWD);
		keys(16'h1111);
		chk("stop", 32'h1, stops);
		expect_msg(`VAD_MSG_WRONG);
		expect_msg(`VAD_MSG_PWD);
		keys(16'h1234);
		expect_msg(`VAD_MSG_OK);
		repeat (3) expect_msg(`VAD_MSG_NORMAL);
		wait_hangup();
		chk("extra plays", 32'h0, msgs.size());
	endtask : test_check_call
	task automatic test_four_wrong();
		u_vad_phone_line.ring_in();
		expect_msg(`VAD_MSG_PWD);
		u_vad_phone_line.press(`VAD_KEY_STAR);
		expect_msg(`VAD_MSG_PWD);
		repeat (3)
		begin
			keys(16'h9999);
			expect_msg(`VAD_MSG_WRONG);
			expect_msg(`VAD_MSG_PWD);
		end
		keys(16'h9999);
		wait_hangup();
		ahb(1'b0, 32'hc, 32'h0);
		chk("wrong count", 32'h0, {30'h0, rd[5:4]});
		msgs.delete();
	endtask : test_four_wrong
	task automatic test_no_answer();
		int n;
		ahb(1'b1, 32'h4, 32'h12);
		dials = '{0, 0};
		door_alarm_input <= 1'b1;
		n = 0;
		while (dial_failure_output !== 1'b1 && n < 5000)
		begin
			@(posedge hclk);
			n++;
		end
		chk("dials primary", 32'h2, dials[0]);
		chk("dials secondary", 32'h2, dials[1]);
		chk("failure", 32'h1, {31'h0, dial_failure_output});
		dials = '{0, 0};
		n = 0;
		while (dials[0] == 0 && n < 600)
		begin
			@(posedge hclk);
			n++;
		end
		chk("retry dial", 32'h1, dials[0]);
		door_alarm_input <= 1'b0;
		wait_hangup();
	endtask : test_no_answer
	task automatic test_alarm_call();
		ahb(1'b1, 32'hc, 32'h2);
		ahb(1'b1, 32'h0, 32'h5a);
		@(posedge hclk);
		chk("failure clear", 32'h0, {31'h0, dial_failure_output});
		u_vad_phone_line.answer <= 1'b1;
		dials = '{0, 0};
		door_alarm_input <= 1'b1;
		expect_msg(`VAD_MSG_KEY0);
		chk("dial primary", 32'h1, dials[0]);
		u_vad_phone_line.press(`VAD_KEY_HASH);
		u_vad_phone_line.press(`VAD_KEY_ZERO);
		expect_msg(`VAD_MSG_PWD);
		keys(`VAD_RST_PWD);
		expect_msg(`VAD_MSG_OK);
		repeat (2) expect_msg(4'h5);
		wait_hangup();
		door_alarm_input <= 1'b0;
		chk("extra plays", 32'h0, msgs.size());
	endtask : test_alarm_call
	task automatic test_direct_call();
		ahb(1'b1, 32'h0, 32'h62);
		@(posedge hclk);
		dials = '{0, 0};
		door_alarm_input <= 1'b1;
		expect_msg(`VAD_MSG_KEY0);
		chk("dial direct", 32'h1, dials[0]);
		u_vad_phone_line.press(`VAD_KEY_HASH);
		u_vad_phone_line.press(`VAD_KEY_ZERO);
		repeat (2) expect_msg(4'h6);
		wait_hangup();
		door_alarm_input <= 1'b0;
		chk("extra direct", 32'h0, msgs.size());
	endtask : test_direct_call
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	initial
	begin
		{hresetn, hsel, hwrite, door_alarm_input} = '0;
		htrans = 2'h0;
		{haddr, hwdata, rd} = '0;
		{err_count, check_count, cyc, stops} = '0;
		dials = '{0, 0};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_regs();
		test_check_call();
		test_four_wrong();
		test_no_answer();
		test_alarm_call();
		test_direct_call();
		complete_run();
	end
endmodule : test_vad_dialer

// File: verif/vad_phone_line.sv
// far side model: telephone line, caller keypad and message player
`timescale 1ns/1ps
module vad_phone_line (
	input  wire logic       hclk,
	input  wire logic       line_hook,
	input  wire logic       dial_req,
	input  wire logic       play_start,
	input  wire logic       play_stop,
	output logic            incoming_ring,
	output logic            line_offhook,
	output logic            ringback,
	output logic            key_valid,
	output logic [3:0]      key_code,
	output logic            play_done
);
	logic answer;
	logic hook_q;
	int   pt;
	int   at;
	int   rt;
	initial
	begin
		{incoming_ring, line_offhook, ringback, key_valid, play_done, answer, hook_q} = '0;
		key_code = 4'h0;
		{pt, at, rt} = '0;
	end
	always @(posedge hclk)
	begin
		hook_q <= line_hook;
		play_done <= (pt == 1);
		if (play_start) pt <= 60;
		else if (play_stop) pt <= 0;
		else if (pt > 0) pt <= pt - 1;
		// far end drops when the line is released
		if (hook_q && !line_hook)
		begin
			line_offhook <= 1'b0;
			incoming_ring <= 1'b0;
		end
		if (dial_req) at <= answer ? 10 : 0;
		else if (at > 1) at <= at - 1;
		else if (at == 1)
		begin
			line_offhook <= 1'b1;
			at <= 0;
		end
		rt <= rt + 1;
		ringback <= line_hook && !line_offhook && !answer && (rt % 10 == 0);
	end
	task automatic ring_in();
		@(posedge hclk);
		incoming_ring <= 1'b1;
		line_offhook <= 1'b1;
	endtask : ring_in
	task automatic press(input logic [3:0] k);
		@(posedge hclk);
		key_code <= k;
		repeat (2) @(posedge hclk);
		key_valid <= 1'b1;
		repeat (4) @(posedge hclk);
		key_valid <= 1'b0;
		repeat (2) @(posedge hclk);
		key_code <= ~k;
	endtask : press
endmodule : vad_phone_line
